// *** logic/ccsc_pkg.sv ***
// Notes on behaviour
// - Sleep after line low over ten seconds while sense magnitude below threshold.
// - In sleep the discharge, charge and self-discharge counters and their prescaler stop; the low-line timer can still count.
// - Rising host data line wakes device and resumes normal operation.
// - Activity output released when effective sense magnitude below threshold.
// - Activity output driven low when activity exceeds threshold, also in sleep; counters run only when awake.
// - Self-discharge rate doubles each ten degree step over the whole step range 0 to 7, below 25 C as well as above.
// - Measured offset stored in offset store at calibration, readable by host.
// - 128-byte array, every byte host read/write; device registers are kept outside it.
// - Host data line is open drain; device only senses it and never drives it (oe held low).
// - Sense a below sense b is discharge; opposite polarity is charge.
// - Threshold is 3.84mV divided by setting 1 to 7; zero invalid.
// - Mode and threshold register resets to 0eh.
package ccsc_pkg;
  localparam int        CLK_HZ           = 50_000_000;
  localparam int        SLEEP_TIME_S     = 10;
  localparam longint    SLEEP_CYCLES     = longint'(SLEEP_TIME_S) * longint'(CLK_HZ);
  localparam logic [7:0] MODE_RESET      = 8'h0e;
  localparam int        WOE_LSB          = 1;
  localparam int        WOE_W            = 3;
  localparam int        MEM_DEPTH        = 128;
  localparam int        DEV_BYTES        = 13;
  localparam int        ADDR_W           = 7;
  localparam int        TEMP_NOMINAL_STEP = 3;
  localparam int        SCR_BASE_DIV     = 128;
  // Threshold numerator in sense LSBs (3.84mV scaled to sense units)
  localparam logic [15:0] WOE_NUMERATOR  = 16'h0133;
  typedef enum logic {CCSC_NORMAL, CCSC_SLEEP} ccsc_state_t;
endpackage : ccsc_pkg

// *** logic/ccsc_store_if.sv ***
`timescale 1ns/1ps
interface ccsc_store_if;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : ccsc_store_if

// *** logic/ccsc_byte_array.sv ***
`timescale 1ns/1ps
module ccsc_byte_array #(
  parameter int DEPTH = ccsc_pkg::MEM_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Access port
  ccsc_store_if.mem st
);
  logic [7:0] mem_ff [DEPTH];
  logic [7:0] nxt_mem [DEPTH];
  logic [7:0] rd_ff;
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (st.we) begin
      nxt_mem[st.addr] = st.wdata;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= 8'h00;
      end
      rd_ff <= 8'h00;
    end else begin
      mem_ff <= nxt_mem;
      rd_ff  <= mem_ff[st.addr];
    end
  end
  assign st.rdata = rd_ff;
endmodule : ccsc_byte_array

// *** logic/ccsc_top.sv ***
`timescale 1ns/1ps
module ccsc_top #(
  parameter longint SLEEP_CYCLES = ccsc_pkg::SLEEP_CYCLES,
  parameter int     CNT_W        = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Host data line, open drain
  input  wire logic              host_data_line_in,
  output logic                   host_data_line_out,
  output logic                   host_data_line_oe,
  // Sense inputs, signed, offset already applied by front end
  input  wire logic signed [15:0] sense_in_a,
  input  wire logic signed [15:0] sense_in_b,
  // Calibration
  input  wire logic              cal_strobe,
  input  wire logic signed [7:0] cal_offset,
  // Temperature step 0..7
  input  wire logic [2:0]        temp_step,
  // Host-side register access
  input  wire logic              host_we,
  input  wire logic [6:0]        host_addr,
  input  wire logic [7:0]        host_wdata,
  input  wire logic [7:0]        mode_wdata,
  input  wire logic              mode_we,
  input  wire logic [2:0]        clear_req,
  output logic [7:0]             host_rdata,
  // Status
  output logic                   activity_out,
  output logic                   activity_oe,
  output logic                   asleep,
  output logic [7:0]             mode_threshold_reg,
  output logic [7:0]             offset_correction_store,
  output logic [CNT_W-1:0]       discharge_accumulator,
  output logic [CNT_W-1:0]       charge_accumulator,
  output logic [CNT_W-1:0]       self_discharge_accumulator
);
  // Host byte array
  ccsc_store_if st ();
  ccsc_byte_array u_arr (.clk(clk), .resetn(resetn), .st(st.mem));

  ccsc_pkg::ccsc_state_t state_ff;
  ccsc_pkg::ccsc_state_t nxt_state;
  logic [39:0]           timer_ff;
  logic [39:0]           nxt_timer;
  logic                  line_ff;
  logic                  nxt_line;
  logic [7:0]            mode_ff;
  logic [7:0]            nxt_mode;
  logic [7:0]            ofr_ff;
  logic [7:0]            nxt_ofr;
  logic [CNT_W-1:0]      dcr_ff;
  logic [CNT_W-1:0]      nxt_dcr;
  logic [CNT_W-1:0]      ccr_ff;
  logic [CNT_W-1:0]      nxt_ccr;
  logic [CNT_W-1:0]      scr_ff;
  logic [CNT_W-1:0]      nxt_scr;
  logic [15:0]           pre_ff;
  logic [15:0]           nxt_pre;
  logic signed [16:0]    vsr;
  logic [16:0]           vmag;
  logic [2:0]            setting;
  logic [15:0]           thresh;
  logic                  active;
  logic                  rise;
  logic [15:0]           scr_div;

  function automatic logic [15:0] woe_thresh(input logic [2:0] s);
    woe_thresh = (s == 3'h0) ? 16'hffff : ccsc_pkg::WOE_NUMERATOR / {13'h0000, s};
  endfunction : woe_thresh

  // Sense magnitude and activity
  assign setting = mode_ff[ccsc_pkg::WOE_LSB +: ccsc_pkg::WOE_W];
  assign thresh  = woe_thresh(setting);
  assign vsr     = 17'(sense_in_b) - 17'(sense_in_a);
  assign vmag    = vsr[16] ? 17'(-vsr) : vsr;
  assign active  = (setting != 3'h0) && (vmag > {1'b0, thresh});
  assign rise    = host_data_line_in && !line_ff;
  // rate doubles per step from step 0 to 7; nominal step is not used
  assign scr_div = 16'(ccsc_pkg::SCR_BASE_DIV) >> temp_step;

  // Low-line timer and line edge detector
  always_comb begin
    nxt_timer = timer_ff;
    nxt_line  = host_data_line_in;
    // timer restarts on line high or activity
    if (host_data_line_in || active) begin
      nxt_timer = 40'h00_0000_0000;
    end else if (timer_ff <= 40'(SLEEP_CYCLES)) begin
      nxt_timer = timer_ff + 40'h00_0000_0001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_ff <= 40'h00_0000_0000;
      // Idle level of the line, so no false edge follows reset
      line_ff  <= 1'b1;
    end else begin
      timer_ff <= nxt_timer;
      line_ff  <= nxt_line;
    end
  end

  // Operating state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ccsc_pkg::CCSC_NORMAL: begin
        if (timer_ff > 40'(SLEEP_CYCLES) && !active && !host_data_line_in) begin
          nxt_state = ccsc_pkg::CCSC_SLEEP;
        end
      end
      ccsc_pkg::CCSC_SLEEP: begin
        if (rise) begin
          nxt_state = ccsc_pkg::CCSC_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ccsc_pkg::CCSC_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Mode and offset registers
  always_comb begin
    nxt_mode = mode_ff;
    nxt_ofr  = ofr_ff;
    if (mode_we) begin
      nxt_mode = mode_wdata;
    end
    if (cal_strobe) begin
      nxt_ofr = cal_offset;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= ccsc_pkg::MODE_RESET;
      ofr_ff  <= 8'h00;
    end else begin
      mode_ff <= nxt_mode;
      ofr_ff  <= nxt_ofr;
    end
  end

  // Counters and self-discharge prescaler
  always_comb begin
    nxt_dcr  = dcr_ff;
    nxt_ccr  = ccr_ff;
    nxt_scr  = scr_ff;
    nxt_pre  = pre_ff;
    if (state_ff == ccsc_pkg::CCSC_NORMAL) begin
      if (vsr > 17'sd0) begin
        nxt_dcr = dcr_ff + CNT_W'(1);
      end else if (vsr < 17'sd0) begin
        nxt_ccr = ccr_ff + CNT_W'(1);
      end
      if (pre_ff >= scr_div - 16'h0001) begin
        nxt_pre = 16'h0000;
        nxt_scr = scr_ff + CNT_W'(1);
      end else begin
        nxt_pre = pre_ff + 16'h0001;
      end
    end
    if (clear_req[0]) begin
      nxt_dcr = '0;
    end
    if (clear_req[1]) begin
      nxt_ccr = '0;
    end
    if (clear_req[2]) begin
      nxt_scr = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dcr_ff  <= '0;
      ccr_ff  <= '0;
      scr_ff  <= '0;
      pre_ff  <= 16'h0000;
    end else begin
      dcr_ff  <= nxt_dcr;
      ccr_ff  <= nxt_ccr;
      scr_ff  <= nxt_scr;
      pre_ff  <= nxt_pre;
    end
  end

  assign st.we    = host_we;
  assign st.addr  = host_addr;
  assign st.wdata = host_wdata;
  assign host_rdata = st.rdata;

  assign host_data_line_out = 1'b0;
  assign host_data_line_oe  = 1'b0;
  assign activity_out = 1'b0;
  assign activity_oe  = active;
  assign asleep       = (state_ff == ccsc_pkg::CCSC_SLEEP);
  assign mode_threshold_reg         = mode_ff;
  assign offset_correction_store    = ofr_ff;
  assign discharge_accumulator      = dcr_ff;
  assign charge_accumulator         = ccr_ff;
  assign self_discharge_accumulator = scr_ff;
endmodule : ccsc_top

// *** dv/ccsc_host_model.sv ***
`timescale 1ns/1ps
module ccsc_host_model (
  // Host pull-down and device pin
  input  wire logic hold_low, dev_out, dev_oe,
  output logic      line
);
  assign line = !(hold_low || (dev_oe && !dev_out));
endmodule : ccsc_host_model

// *** dv/ccsc_top_sva.sv ***
`timescale 1ns/1ps
module ccsc_top_sva #(parameter longint SLEEP_CYCLES = 20) (
  // Watched ports
  input wire logic               clk, resetn, host_data_line_in, host_data_line_oe,
  input wire logic               cal_strobe, activity_out, activity_oe, asleep,
  input wire logic signed [15:0] sense_in_a, sense_in_b,
  input wire logic signed [7:0]  cal_offset,
  input wire logic [2:0]         clear_req,
  input wire logic [7:0]         mode_threshold_reg, offset_correction_store,
  input wire logic [15:0]        discharge_accumulator, charge_accumulator, self_discharge_accumulator
);
  logic [15:0] mag, thr;
  longint      low_ff, nxt_low;
  always_comb begin
    mag = 16'(sense_in_b > sense_in_a ? sense_in_b - sense_in_a : sense_in_a - sense_in_b);
    thr = mode_threshold_reg[3:1] == 3'h0 ? 16'hffff : ccsc_pkg::WOE_NUMERATOR / mode_threshold_reg[3:1];
    nxt_low = host_data_line_in || activity_oe ? 0 : low_ff + longint'(low_ff < SLEEP_CYCLES + 9);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_ff <= 0;
    else low_ff <= nxt_low;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_act_thr: assert property (activity_oe == (mag > thr)) else $error("activity off threshold");
  a_act_low: assert property (activity_oe |-> !activity_out) else $error("activity not low");
  a_line_free: assert property (!host_data_line_oe) else $error("line driven");
  a_sleep_late: assert property (low_ff >= SLEEP_CYCLES + 2 |-> asleep) else $error("no sleep");
  a_sleep_early: assert property (!asleep && low_ff <= SLEEP_CYCLES |=> !asleep) else $error("early sleep");
  a_wake_rise: assert property (asleep && $rose(host_data_line_in) |-> ##[1:2] !asleep) else $error("no wake");
  a_sleep_hold: assert property (asleep && clear_req == 3'h0 |=>
    $stable({discharge_accumulator, charge_accumulator, self_discharge_accumulator})) else $error("count in sleep");
  a_cal_load: assert property (cal_strobe |=> offset_correction_store == $past(cal_offset)) else $error("ofs");
  c_wake: cover property (asleep ##1 !asleep);
  c_act: cover property (activity_oe);
  c_cal: cover property (cal_strobe);
  c_sleep: cover property ($rose(asleep));
endmodule : ccsc_top_sva
bind ccsc_top ccsc_top_sva #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_ccsc_top_sva (.*);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam longint SC = 20;
  logic clk = 0, resetn = 0, hold_low = 0, cal_strobe = 0, host_we = 0, mode_we = 0;
  logic host_data_line_in, host_data_line_out, host_data_line_oe, activity_out, activity_oe, asleep;
  logic signed [15:0] sense_in_a = 16'h0000, sense_in_b = 16'h0000;
  logic signed [7:0]  cal_offset = 8'h00;
  logic [2:0]  temp_step = 3'h3, clear_req = 3'h0;
  logic [6:0]  host_addr = 7'h00;
  logic [7:0]  host_wdata = 8'h00, mode_wdata = 8'h00, host_rdata, mode_threshold_reg, offset_correction_store;
  logic [15:0] discharge_accumulator, charge_accumulator, self_discharge_accumulator, d, c, q, th;
  int n_errors = 0, num_checks = 0;
  always #10 clk = ~clk;
  ccsc_host_model i_ccsc_host_model (.hold_low, .dev_out(host_data_line_out), .dev_oe(host_data_line_oe),
    .line(host_data_line_in));
  ccsc_top #(.SLEEP_CYCLES(SC)) i_ccsc_top (.*);
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task report_and_stop;
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task act(input logic [15:0] a, input logic [15:0] b, input logic e);
    @(posedge clk);
    sense_in_a <= a;
    sense_in_b <= b;
    #1 chk("activity_oe", 16'(e), 16'(activity_oe));
  endtask : act
  task t_act;
    chk("mode_reg", 16'h000e, 16'(mode_threshold_reg));
    for (int s = 0; s < 8; s++) begin
      th = s == 0 ? 16'h0100 : 16'(ccsc_pkg::WOE_NUMERATOR / s);
      @(posedge clk);
      mode_wdata <= 8'(s << 1);
      mode_we <= 1'b1;
      @(posedge clk);
      mode_we <= 1'b0;
      act(16'h0000, th, 1'b0);
      act(16'h0000, th + 16'h0001, s != 0);
      act(th + 16'h0001, 16'h0000, s != 0);
    end
  endtask : t_act
  task t_dir;
    act(16'h0000, 16'h0100, 1'b1);
    temp_step <= 3'h7;
    step(2);
    #1 d = discharge_accumulator;
    c = charge_accumulator;
    q = self_discharge_accumulator;
    step(200);
    #1 chk("scr_rate", 16'h00c8, self_discharge_accumulator - q);
    chk("ccr_idle", c, charge_accumulator);
    chk("dcr_move", 16'h0001, 16'(discharge_accumulator != d));
    temp_step <= 3'h3;
  endtask : t_dir
  task t_sleep;
    act(16'h0000, 16'h0001, 1'b0);
    hold_low <= 1'b1;
    temp_step <= 3'h7;
    step(SC - 2);
    #1 chk("early", 16'h0000, 16'(asleep));
    @(posedge clk) hold_low <= 1'b0;
    @(posedge clk) hold_low <= 1'b1;
    step(SC - 2);
    #1 chk("restart", 16'h0000, 16'(asleep));
    step(8);
    #1 chk("asleep", 16'h0001, 16'(asleep));
    d = discharge_accumulator;
    c = charge_accumulator;
    q = self_discharge_accumulator;
    step(6);
    #1 chk("dcr_held", d, discharge_accumulator);
    chk("ccr_held", c, charge_accumulator);
    chk("scr_held", q, self_discharge_accumulator);
    @(posedge clk) hold_low <= 1'b0;
    step(2);
    #1 chk("woke", 16'h0000, 16'(asleep));
    d = discharge_accumulator;
    step(4);
    #1 chk("resumed", 16'h0001, 16'(discharge_accumulator != d));
    temp_step <= 3'h3;
  endtask : t_sleep
  task t_misc;
    @(posedge clk);
    cal_offset <= 8'hfd;
    cal_strobe <= 1'b1;
    clear_req <= 3'h7;
    host_we <= 1'b1;
    host_addr <= 7'h72;
    host_wdata <= 8'h5a;
    @(posedge clk);
    cal_strobe <= 1'b0;
    clear_req <= 3'h0;
    host_we <= 1'b0;
    #1 chk("ofs", 16'h00fd, 16'(offset_correction_store));
    chk("cnt_clr", 16'h0000, discharge_accumulator | charge_accumulator | self_discharge_accumulator);
    chk("true_dcr", 16'h0003, discharge_accumulator - 16'($signed(offset_correction_store)));
    chk("line_drive", 16'h0000, 16'({host_data_line_out, host_data_line_oe}));
    chk("activity_level", 16'h0000, 16'(activity_out));
    step(1);
    #1 chk("rdata", 16'h005a, 16'(host_rdata));
  endtask : t_misc
  initial begin
    step(12);
    resetn <= 1'b1;
    t_act();
    t_dir();
    t_sleep();
    t_misc();
    report_and_stop();
  end
  initial begin
    step(3000);
    n_errors++;
    report_and_stop();
  end
endmodule : testbench
